// File: design/uart_line_pkg.sv
// constants shared by the uart fifo and line control block
// assumes a host register port with a small select code instead of a bus
package uart_line_pkg;
  // register select codes; status reads and fifo control writes share one code
  localparam logic [1:0] SEL_STATUS_FIFO = 2'h0;
  localparam logic [1:0] SEL_LINE_FORMAT = 2'h1;
  typedef logic [1:0] reg_sel_t;

  // fifo_control fields
  localparam int FC_ENABLE   = 0;
  localparam int FC_RX_CLEAR = 1;
  localparam int FC_TX_CLEAR = 2;
  localparam int FC_WAKE     = 3;
  localparam int FC_TX_LO    = 4;
  localparam int FC_RX_LO    = 6;

  // interrupt_source_status fields
  localparam int IS_MATCH = 4;
  localparam int IS_FLOW  = 5;
  localparam int IS_GPIO  = 6;
  localparam int IS_FIFO  = 7;

  // line_format fields
  localparam int LF_STOP = 2;
  localparam logic [7:0] LINE_FORMAT_RESET = 8'h00;
  localparam logic [3:0] WORD_BASE         = 4'h5;
  // stop length in half bit times
  localparam logic [2:0] STOP_ONE      = 3'h2;
  localparam logic [2:0] STOP_ONE_HALF = 3'h3;
  localparam logic [2:0] STOP_TWO      = 3'h4;

  // trigger tables
  typedef enum logic [1:0] {TABLE_A, TABLE_B, TABLE_C, TABLE_D} trig_table_t;
  localparam logic [7:0] RX_A0 = 8'h01, RX_A1 = 8'h04, RX_A2 = 8'h08, RX_A3 = 8'h0e;
  localparam logic [7:0] TX_A  = 8'h01;
  localparam logic [7:0] RX_B0 = 8'h08, RX_B1 = 8'h10, RX_B2 = 8'h18, RX_B3 = 8'h1c;
  localparam logic [7:0] TX_B0 = 8'h10, TX_B1 = 8'h08, TX_B2 = 8'h18, TX_B3 = 8'h1e;
  localparam logic [7:0] RX_C0 = 8'h08, RX_C1 = 8'h10, RX_C2 = 8'h38, RX_C3 = 8'h3c;
  localparam logic [7:0] TX_C0 = 8'h08, TX_C1 = 8'h10, TX_C2 = 8'h20, TX_C3 = 8'h38;
  localparam logic [7:0] PROG_RESET = 8'h01;
  localparam logic [1:0] CODE_RESET = 2'h0;
endpackage

// File: design/uart_fifo_line_control.sv
// fifo control, interrupt status upper bits and line format of a uart channel
// assumes fifo counts, flow pins and gpio/match events arrive synchronous to mclk
`timescale 1ns/1ns
module uart_fifo_line_control #(
  parameter int LEVEL_W = 8
) (
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire logic                     wr_en,
  input  wire uart_line_pkg::reg_sel_t  wr_sel,
  input  wire logic [7:0]               wr_data,
  input  wire logic                     rd_valid,
  output logic                          rd_ready,
  input  wire uart_line_pkg::reg_sel_t  rd_sel,
  output logic                          rsp_valid,
  input  wire logic                     rsp_ready,
  output logic [7:0]                    rsp_data,
  input  wire logic                     enhanced_enable,
  input  wire uart_line_pkg::trig_table_t table_sel,
  input  wire logic                     prog_trig_wr,
  input  wire logic                     prog_trig_tx,
  input  wire logic [7:0]               prog_trig_value,
  input  wire logic                     gpio_pending,
  input  wire logic                     cts_level,
  input  wire logic                     rts_level,
  input  wire logic                     flow_status_clear,
  input  wire logic                     char_match,
  input  wire logic [3:0]               low_status,
  input  wire logic [LEVEL_W-1:0]       rx_count,
  input  wire logic [LEVEL_W-1:0]       tx_count,
  output logic                          fifo_enable,
  output logic                          rx_fifo_clear,
  output logic                          tx_fifo_clear,
  output logic                          wake_int_enable,
  output logic                          rx_irq,
  output logic                          tx_irq,
  output logic [3:0]                    word_bits,
  output logic [2:0]                    stop_half_bits,
  output logic [7:0]                    line_format
);
  import uart_line_pkg::*;

  generate
    if (LEVEL_W < 8) begin : g_width_check
      $error("LEVEL_W must hold trigger levels up to 8 bits");
    end
  endgenerate

  // one of four levels chosen by a two-bit trigger code
  function automatic logic [7:0] pick4(input logic [1:0] code,
                                       input logic [7:0] l0,
                                       input logic [7:0] l1,
                                       input logic [7:0] l2,
                                       input logic [7:0] l3);
    logic [7:0] lvl;
    lvl = l0;
    unique case (code)
      2'h0: lvl = l0;
      2'h1: lvl = l1;
      2'h2: lvl = l2;
      2'h3: lvl = l3;
    endcase
    return lvl;
  endfunction

  function automatic logic [7:0] trig_level(input trig_table_t tbl,
                                            input logic [1:0]  code,
                                            input logic        is_tx,
                                            input logic [7:0]  prog);
    logic [7:0] lvl;
    lvl = prog;
    unique case (tbl)
      TABLE_A: begin
        // table a has a single transmit level whatever the code
        lvl = is_tx ? TX_A : pick4(code, RX_A0, RX_A1, RX_A2, RX_A3);
      end
      TABLE_B: begin
        lvl = is_tx ? pick4(code, TX_B0, TX_B1, TX_B2, TX_B3)
                    : pick4(code, RX_B0, RX_B1, RX_B2, RX_B3);
      end
      TABLE_C: begin
        lvl = is_tx ? pick4(code, TX_C0, TX_C1, TX_C2, TX_C3)
                    : pick4(code, RX_C0, RX_C1, RX_C2, RX_C3);
      end
      TABLE_D: begin
        lvl = prog;
      end
    endcase
    return lvl;
  endfunction

  logic [1:0] rx_code;
  logic [1:0] tx_code;
  logic       wake_bit;
  logic [7:0] rx_prog;
  logic [7:0] tx_prog;
  logic       flow_flag;
  logic       cts_prev;
  logic       rts_prev;
  logic       tx_filled;
  logic [7:0] buf_data [2];
  logic       buf_wr;
  logic       buf_rd;
  logic [1:0] buf_count;

  // decode
  wire fc_write   = wr_en && wr_sel == SEL_STATUS_FIFO;
  wire lf_write   = wr_en && wr_sel == SEL_LINE_FORMAT;
  wire fc_armed   = fc_write && wr_data[FC_ENABLE];
  wire flow_rise  = enhanced_enable && ((cts_level && !cts_prev) || (rts_level && !rts_prev));
  wire [7:0] rx_level = trig_level(table_sel, rx_code, 1'b0, rx_prog);
  wire [7:0] tx_level = trig_level(table_sel, tx_code, 1'b1, tx_prog);
  wire [LEVEL_W-1:0] rx_lvl_w = LEVEL_W'(rx_level);
  wire [LEVEL_W-1:0] tx_lvl_w = LEVEL_W'(tx_level);

  // status is formed from the present state, sampled into the read buffer at the edge that accepts the read
  wire [7:0] isr_now = {fifo_enable,
                        fifo_enable ^ gpio_pending,
                        flow_flag,
                        enhanced_enable && char_match,
                        low_status};
  wire [7:0] read_value = rd_sel == SEL_STATUS_FIFO ? isr_now :
                          rd_sel == SEL_LINE_FORMAT ? line_format : 8'h00;

  assign wake_int_enable = enhanced_enable && wake_bit;
  assign rx_irq = fifo_enable && rx_count >= rx_lvl_w;
  // below trigger after a fill above it, else only at empty
  assign tx_irq = fifo_enable && (tx_filled ? tx_count < tx_lvl_w
                                            : tx_count == '0);
  assign word_bits = WORD_BASE + {2'b00, line_format[1:0]};
  assign stop_half_bits = !line_format[LF_STOP]    ? STOP_ONE :
                          line_format[1:0] == 2'h0 ? STOP_ONE_HALF : STOP_TWO;

  always_ff @(posedge mclk) begin
    if (rst) begin
      fifo_enable <= 1'b0;
      rx_code     <= CODE_RESET;
      tx_code     <= CODE_RESET;
      wake_bit    <= 1'b0;
    end else if (fc_write) begin
      fifo_enable <= wr_data[FC_ENABLE];
      if (wr_data[FC_ENABLE]) begin
        rx_code  <= wr_data[FC_RX_LO +: 2];
        wake_bit <= wr_data[FC_WAKE];
        if (enhanced_enable)
          tx_code <= wr_data[FC_TX_LO +: 2];
      end
    end
  end

  // a one-cycle pulse stands in for the self-clearing reset bits
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_fifo_clear <= 1'b0;
      tx_fifo_clear <= 1'b0;
    end else begin
      rx_fifo_clear <= fc_armed && wr_data[FC_RX_CLEAR];
      tx_fifo_clear <= fc_armed && wr_data[FC_TX_CLEAR];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_prog <= PROG_RESET;
      tx_prog <= PROG_RESET;
    end else if (prog_trig_wr) begin
      if (prog_trig_tx)
        tx_prog <= prog_trig_value;
      else
        rx_prog <= prog_trig_value;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst)
      line_format <= LINE_FORMAT_RESET;
    else if (lf_write)
      line_format <= wr_data;
  end

  // set wins over clear so an edge in the clearing cycle is kept
  always_ff @(posedge mclk) begin
    if (rst) begin
      flow_flag <= 1'b0;
      cts_prev  <= 1'b0;
      rts_prev  <= 1'b0;
    end else begin
      cts_prev  <= cts_level;
      rts_prev  <= rts_level;
      flow_flag <= flow_rise || (flow_flag && !flow_status_clear);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || tx_fifo_clear)
      tx_filled <= 1'b0;
    else if (tx_count > tx_lvl_w)
      tx_filled <= 1'b1;
    else if (tx_count == '0)
      tx_filled <= 1'b0;
  end

  // two-entry read buffer: a stalled host loses no answer
  assign rd_ready  = buf_count != 2'h2;
  assign rsp_valid = buf_count != 2'h0;
  assign buf_wr    = rd_valid && rd_ready;
  assign buf_rd    = rsp_valid && rsp_ready;
  assign rsp_data  = buf_data[0];

  always_ff @(posedge mclk) begin
    if (rst) begin
      buf_count   <= 2'h0;
      buf_data[0] <= 8'h00;
      buf_data[1] <= 8'h00;
    end else begin
      buf_count <= buf_count + {1'b0, buf_wr} - {1'b0, buf_rd};
      if (buf_rd) begin
        buf_data[0] <= (buf_count == 2'h2) ? buf_data[1] : read_value;
        if (buf_wr)
          buf_data[buf_count == 2'h2 ? 1 : 0] <= read_value;
      end else if (buf_wr) begin
        buf_data[buf_count == 2'h0 ? 0 : 1] <= read_value;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  fifo_enable_a: assert property (fc_write |=> fifo_enable == $past(wr_data[FC_ENABLE]))
    else $error("fifo enable does not follow write");
  gated_write_a: assert property (fc_write && !wr_data[FC_ENABLE] |=> $stable(rx_code))
    else $error("trigger code changed without enable bit");
  rx_clear_a: assert property (fc_armed && wr_data[FC_RX_CLEAR] |=> rx_fifo_clear ##1 !rx_fifo_clear)
    else $error("rx clear pulse wrong");
  tx_clear_a: assert property (fc_armed && wr_data[FC_TX_CLEAR] |=> tx_fifo_clear ##1 !tx_fifo_clear)
    else $error("tx clear pulse wrong");
  gpio_invert_a: assert property (gpio_pending |-> isr_now[IS_GPIO] != isr_now[IS_FIFO])
    else $error("gpio bit not inverted");
  legacy_match_a: assert property (!gpio_pending |-> isr_now[IS_GPIO] == fifo_enable)
    else $error("gpio bit does not match fifo bit");
  tx_select_guard_a: assert property (fc_write && !enhanced_enable |=> $stable(tx_code))
    else $error("tx code written outside enhanced mode");
  flow_set_a: assert property (enhanced_enable && $rose(cts_level) |=> flow_flag)
    else $error("flow change not flagged");
  rx_trigger_a: assert property (fifo_enable && rx_count >= rx_lvl_w |-> rx_irq)
    else $error("rx interrupt missing at trigger");
  word_length_a: assert property (lf_write |=> word_bits == WORD_BASE + {2'b00, $past(wr_data[1:0])})
    else $error("word length wrong");
  wake_gate_a: assert property (!enhanced_enable |-> !wake_int_enable)
    else $error("wake enable outside enhanced mode");

  // flow flag: cleared only without a new edge, never set outside enhanced mode
  flow_clear_a: assert property (flow_status_clear && !flow_rise |=> !flow_flag)
    else $error("flow flag not cleared");
  flow_gate_a: assert property (!enhanced_enable && !flow_flag |=> !flow_flag)
    else $error("flow flag set outside enhanced mode");
  match_gate_a: assert property (!enhanced_enable |-> !isr_now[IS_MATCH])
    else $error("match bit outside enhanced mode");

  // stored fifo control fields other than the enable bit follow only armed writes
  wake_store_a: assert property (fc_armed |=> wake_bit == $past(wr_data[FC_WAKE]))
    else $error("wake bit not stored");
  rx_code_store_a: assert property (fc_armed |=> rx_code == $past(wr_data[FC_RX_LO +: 2]))
    else $error("rx code not stored");
  tx_code_store_a: assert property (fc_armed && enhanced_enable |=>
                                    tx_code == $past(wr_data[FC_TX_LO +: 2]))
    else $error("tx code not stored");
  no_clear_a: assert property (fc_write && !wr_data[FC_ENABLE] |=> !rx_fifo_clear && !tx_fifo_clear)
    else $error("clear pulse without enable bit");
  clear_idle_a: assert property (!fc_armed |=> !rx_fifo_clear && !tx_fifo_clear)
    else $error("clear pulse without a write");

  // trigger levels checked against the table constants, not the decoder
  table_a_tx_a: assert property (table_sel == TABLE_A |-> tx_level == TX_A)
    else $error("table a tx level wrong");
  table_a_rx_a: assert property (table_sel == TABLE_A && rx_code == 2'h3 |-> rx_level == RX_A3)
    else $error("table a rx level wrong");
  table_b_tx_a: assert property (table_sel == TABLE_B && tx_code == 2'h3 |-> tx_level == TX_B3)
    else $error("table b tx level wrong");
  table_d_a: assert property (table_sel == TABLE_D |-> rx_level == rx_prog && tx_level == tx_prog)
    else $error("table d levels wrong");
  rx_prog_a: assert property (prog_trig_wr && !prog_trig_tx |=> rx_prog == $past(prog_trig_value))
    else $error("rx programmable level not stored");
  tx_prog_a: assert property (prog_trig_wr && prog_trig_tx |=> tx_prog == $past(prog_trig_value))
    else $error("tx programmable level not stored");

  // interrupt levels; a zero programmed level holds the tx interrupt at empty back one cycle after a fill, hence the table guard
  fifo_off_a: assert property (!fifo_enable |-> !tx_irq && !rx_irq)
    else $error("fifo interrupt while fifos off");
  rx_below_a: assert property (rx_count < rx_lvl_w |-> !rx_irq)
    else $error("rx interrupt below trigger");
  tx_empty_a: assert property (fifo_enable && table_sel != TABLE_D && tx_count == '0 |-> tx_irq)
    else $error("tx interrupt missing at empty");
  tx_low_fill_a: assert property (!tx_filled && tx_count != '0 |-> !tx_irq)
    else $error("tx interrupt after a low fill");

  // line format decode
  word_eight_a: assert property (line_format[1:0] == 2'h3 |-> word_bits == WORD_BASE + 4'h3)
    else $error("eight bit length wrong");
  stop_one_a: assert property (!line_format[LF_STOP] |-> stop_half_bits == STOP_ONE)
    else $error("single stop wrong");
  stop_half_a: assert property (line_format[LF_STOP] && line_format[1:0] == 2'h0 |->
                                stop_half_bits == STOP_ONE_HALF)
    else $error("one and a half stop wrong");
  stop_two_a: assert property (line_format[LF_STOP] && line_format[1:0] != 2'h0 |->
                               stop_half_bits == STOP_TWO)
    else $error("two stop bits wrong");
  format_hold_a: assert property (!lf_write |=> $stable(line_format))
    else $error("line format changed without write");

  // read answers carry the value live at the accepting edge
  read_format_a: assert property (buf_wr && buf_count == 2'h0 && rd_sel == SEL_LINE_FORMAT |=>
                                  rsp_data == $past(line_format))
    else $error("line format read wrong");
  read_status_a: assert property (buf_wr && buf_count == 2'h0 && rd_sel == SEL_STATUS_FIFO |=>
                                  rsp_data[IS_FIFO] == $past(fifo_enable))
    else $error("status read not live");
  buffer_full_a: assert property (buf_count == 2'h2 |-> !rd_ready && buf_count != 2'h3)
    else $error("read buffer overfilled");

  rx_clear_c: cover property (fc_armed && wr_data[FC_RX_CLEAR]);
  table_d_c: cover property (table_sel == TABLE_D && rx_irq);
  buffer_full_c: cover property (buf_count == 2'h2 && rd_valid);
  tx_empty_c: cover property (fifo_enable && !tx_filled && tx_irq);
  flow_flag_c: cover property (flow_rise && flow_status_clear);
endmodule

// File: tb/fifo_level_model.sv
// fifo fill-count model standing behind the control block
// assumes the bench preloads counts through load before using them
`timescale 1ns/1ns
module fifo_level_model (
  input  wire logic       mclk,
  input  wire logic       rx_fifo_clear,
  input  wire logic       tx_fifo_clear,
  input  wire logic       load,
  input  wire logic [7:0] rx_load,
  input  wire logic [7:0] tx_load,
  output logic      [7:0] rx_count,
  output logic      [7:0] tx_count
);
  // clear wins over a load in the same cycle, as a pointer reset would
  always_ff @(posedge mclk) begin
    if (rx_fifo_clear) rx_count <= 8'h00;
    else if (load) rx_count <= rx_load;
    if (tx_fifo_clear) tx_count <= 8'h00;
    else if (load) tx_count <= tx_load;
  end
endmodule

// File: tb/uart_fifo_line_control_tb_top.sv
// self-checking bench for the fifo and line control block
// assumes the fifo_level_model partner and the uart_line_pkg package
`timescale 1ns/1ns
module uart_fifo_line_control_tb_top;
  import uart_line_pkg::*;
  logic        mclk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_valid = 1'b0, rsp_ready = 1'b1;
  logic        en = 1'b0, ptw = 1'b0, ptx = 1'b0, gpio = 1'b0, cts = 1'b0, rts = 1'b0;
  logic        fclr = 1'b0, cm = 1'b0, load = 1'b0;
  reg_sel_t    wr_sel = 2'h0, rd_sel = 2'h0;
  trig_table_t tsel = TABLE_A;
  logic [7:0]  wr_data = 8'h00, pval = 8'h00, rx_ld = 8'h00, tx_ld = 8'h00;
  logic [7:0]  rsp_data, s, rx_count, tx_count, line_format;
  logic        rd_ready, rsp_valid, fifo_enable, rx_clr, tx_clr, wake, rx_irq, tx_irq;
  logic [3:0]  word_bits;
  logic [2:0]  stop_half_bits;
  int          mismatches = 0, checks_done = 0, cycles = 0;
  localparam int RXL[12] = '{1, 4, 8, 14, 8, 16, 24, 28, 8, 16, 56, 60};

  always #10 mclk = ~mclk;

  uart_fifo_line_control #(.LEVEL_W(8)) dut (
    .mclk, .rst, .wr_en, .wr_sel, .wr_data, .rd_valid, .rd_ready, .rd_sel,
    .rsp_valid, .rsp_ready, .rsp_data, .enhanced_enable(en), .table_sel(tsel),
    .prog_trig_wr(ptw), .prog_trig_tx(ptx), .prog_trig_value(pval),
    .gpio_pending(gpio), .cts_level(cts), .rts_level(rts), .flow_status_clear(fclr),
    .char_match(cm), .low_status(4'h5), .rx_count, .tx_count, .fifo_enable,
    .rx_fifo_clear(rx_clr), .tx_fifo_clear(tx_clr), .wake_int_enable(wake),
    .rx_irq, .tx_irq, .word_bits, .stop_half_bits, .line_format
  );

  fifo_level_model partner (
    .mclk, .rx_fifo_clear(rx_clr), .tx_fifo_clear(tx_clr), .load,
    .rx_load(rx_ld), .tx_load(tx_ld), .rx_count, .tx_count
  );

  task step;
    @(posedge mclk);
    #1;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task wr(input reg_sel_t a, input logic [7:0] d);
    wr_en = 1'b1;
    wr_sel = a;
    wr_data = d;
    step;
    wr_en = 1'b0;
  endtask
  // answer waits are bounded so a dead read port cannot hang the run
  task rd(input reg_sel_t a, output logic [7:0] d);
    int n;
    rd_valid = 1'b1;
    rd_sel = a;
    step;
    rd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 8) begin
      step;
      n++;
    end
    d = rsp_data;
    step;
  endtask
  task ld(input logic [7:0] r, input logic [7:0] t);
    rx_ld = r;
    tx_ld = t;
    load = 1'b1;
    step;
    load = 1'b0;
  endtask
  task irq(input logic got, input logic exp, input string m);
    chk({7'h0, got}, {7'h0, exp}, m);
  endtask

  task t_reset;
    ld(8'h00, 8'h00);
    chk({4'h0, word_bits}, 8'h05, "word");
    chk({5'h0, stop_half_bits}, 8'h02, "stop");
    irq(fifo_enable, 1'b0, "fifo en");
    rd(SEL_STATUS_FIFO, s);
    chk(s, 8'h05, "status");
    rd(SEL_LINE_FORMAT, s);
    chk(s, 8'h00, "format");
    $display("reset test done");
  endtask

  task t_fifo;
    ld(8'h14, 8'h14);
    wr(SEL_STATUS_FIFO, 8'h07);
    chk({5'h0, fifo_enable, rx_clr, tx_clr}, 8'h07, "enable clears");
    step;
    chk({6'h0, rx_clr, tx_clr}, 8'h00, "self clear");
    chk(rx_count | tx_count, 8'h00, "counts");
    rd(SEL_STATUS_FIFO, s);
    chk(s, 8'hc5, "on no gpio");
    gpio = 1'b1;
    rd(SEL_STATUS_FIFO, s);
    chk(s, 8'h85, "on gpio");
    wr(SEL_STATUS_FIFO, 8'hc6);
    chk({5'h0, fifo_enable, rx_clr, tx_clr}, 8'h00, "bit0 low");
    rd(SEL_STATUS_FIFO, s);
    chk(s, 8'h45, "off gpio");
    gpio = 1'b0;
    rd(SEL_STATUS_FIFO, s);
    chk(s, 8'h05, "off");
    $display("fifo enable test done");
  endtask

  task t_line;
    for (int i = 0; i < 8; i++) begin
      wr(SEL_LINE_FORMAT, 8'ha8 | 8'(i));
      chk({4'h0, word_bits}, 8'(5 + i % 4), "word");
      chk({5'h0, stop_half_bits}, (i < 4) ? 8'h02 : (i == 4) ? 8'h03 : 8'h04, "stop");
      chk(line_format, 8'ha8 | 8'(i), "format pin");
      rd(SEL_LINE_FORMAT, s);
      chk(s, 8'ha8 | 8'(i), "format");
    end
    $display("line format test done");
  endtask

  task t_rx;
    en = 1'b1;
    for (int t = 0; t < 3; t++) begin
      tsel = trig_table_t'(t);
      for (int c = 0; c < 4; c++) begin
        wr(SEL_STATUS_FIFO, {2'(c), 6'h01});
        ld(8'(RXL[t * 4 + c] - 1), 8'h00);
        irq(rx_irq, 1'b0, "rx below");
        ld(8'(RXL[t * 4 + c]), 8'h00);
        irq(rx_irq, 1'b1, "rx level");
      end
    end
    tsel = TABLE_D;
    pval = 8'h21;
    ptw = 1'b1;
    step;
    ptw = 1'b0;
    ld(8'h20, 8'h00);
    irq(rx_irq, 1'b0, "prog below");
    ld(8'h21, 8'h00);
    irq(rx_irq, 1'b1, "prog level");
    ptx = 1'b1;
    pval = 8'h03;
    ptw = 1'b1;
    step;
    ptw = 1'b0;
    ptx = 1'b0;
    ld(8'h00, 8'h04);
    ld(8'h00, 8'h02);
    irq(tx_irq, 1'b1, "prog tx level");
    $display("rx trigger test done");
  endtask

  task t_tx;
    tsel = TABLE_B;
    wr(SEL_STATUS_FIFO, 8'h39);
    irq(wake, 1'b1, "wake on");
    ld(8'h00, 8'h1f);
    ld(8'h00, 8'h1d);
    irq(tx_irq, 1'b1, "tx below");
    ld(8'h00, 8'h1e);
    irq(tx_irq, 1'b0, "tx at");
    en = 1'b0;
    step;
    irq(wake, 1'b0, "wake gated");
    wr(SEL_STATUS_FIFO, 8'h01);
    ld(8'h00, 8'h1d);
    irq(tx_irq, 1'b1, "tx code kept");
    tsel = TABLE_C;
    ld(8'h00, 8'h37);
    irq(tx_irq, 1'b1, "table swap");
    wr(SEL_STATUS_FIFO, 8'h05);
    step;
    ld(8'h00, 8'h05);
    irq(tx_irq, 1'b0, "low fill");
    ld(8'h00, 8'h00);
    irq(tx_irq, 1'b1, "empty");
    $display("tx trigger test done");
  endtask

  task t_flow;
    en = 1'b1;
    cm = 1'b1;
    cts = 1'b1;
    repeat (3) step;
    rd(SEL_STATUS_FIFO, s);
    irq(s[5], 1'b1, "flow set");
    irq(s[4], 1'b1, "match");
    fclr = 1'b1;
    step;
    fclr = 1'b0;
    en = 1'b0;
    rts = 1'b1;
    repeat (3) step;
    rd(SEL_STATUS_FIFO, s);
    irq(s[5], 1'b0, "flow gated");
    irq(s[4], 1'b0, "match gated");
    $display("flow status test done");
  endtask

  // host stalls the answers so the read buffer must fill and refuse
  task t_buf;
    rsp_ready = 1'b0;
    rd_valid = 1'b1;
    rd_sel = SEL_LINE_FORMAT;
    repeat (2) step;
    chk({6'h0, rd_ready, rsp_valid}, 8'h01, "buffer full");
    chk(rsp_data, 8'haf, "head answer");
    rd_valid = 1'b0;
    rsp_ready = 1'b1;
    repeat (2) step;
    irq(rsp_valid, 1'b0, "drained");
    $display("read buffer test done");
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      summarize;
    end
  end

  initial begin
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_reset;
    t_fifo;
    t_line;
    t_rx;
    t_tx;
    t_flow;
    t_buf;
    summarize;
  end
endmodule
